// [umh_modem_handshake.sv]
/*
 * Modem handshake logic for the primary (index 0) and secondary (index 1)
 * serial ports: terminal-ready and send-request outputs, modem status word
 * with change flags, and the modem-status interrupt request.
 * Assumes the modem pins are asynchronous to i_mclk; control and enable
 * words come from same-clock UART register logic; the status read strobe
 * is a one-cycle pulse on i_mclk.
 */
`timescale 1ns/10ps
`include "umh_defines.svh"

// Functional notes
// RQ1: Terminal-ready pin is driven low when control bit 0 is set.
// RQ2: Hardware reset leaves terminal-ready high, inactive.
// RQ3: Loopback mode forces terminal-ready inactive whatever the control bit.
// RQ4: Status bit 4 is the inverse of the clear-to-send pin.
// RQ5: Clear-to-send rising since last status read sets status bit 0.
// RQ6: With enable bit 3, clear-to-send change raises modem interrupt. The code raises it only on the pin's low-to-high rise.
// RQ7: Clear-to-send never gates the transmitter.
// RQ8: Status bit 5 is the inverse of the set-ready pin.
// RQ9: Set-ready rising since last status read sets status bit 1.
// RQ10: With enable bit 3, set-ready change raises modem interrupt. The code raises it only on the pin's low-to-high rise.
// RQ11: Status bit 7 is the inverse of the carrier-detect pin.
// RQ12: Carrier-detect rising since last status read sets status bit 3.
// RQ13: With enable bit 3, carrier-detect change raises modem interrupt. The code raises it only on the pin's low-to-high rise.
// RQ14: Two independent copies, primary and secondary, own pins and registers.
// RQ15: Send-request driven from control bit 1, high at reset, off in loopback.
// RQ16: Status bit 6 inverts ring; its rise sets bit 2 and interrupts.
// RQ17: Status read clears flags 0 to 3; interrupt drops when none set.
module umh_modem_handshake
  import umh_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_modem_control_reg_primary,
  input  wire logic [7:0] i_modem_control_reg_secondary,
  input  wire logic [7:0] i_int_enable_primary,
  input  wire logic [7:0] i_int_enable_secondary,
  input  wire logic       i_status_read_primary,
  input  wire logic       i_status_read_secondary,
  input  wire logic       i_clear_to_send_in_n_primary,
  input  wire logic       i_clear_to_send_in_n_secondary,
  input  wire logic       i_set_ready_in_n_primary,
  input  wire logic       i_set_ready_in_n_secondary,
  input  wire logic       i_carrier_detect_in_n_primary,
  input  wire logic       i_carrier_detect_in_n_secondary,
  input  wire logic       i_ring_in_n_primary,
  input  wire logic       i_ring_in_n_secondary,
  output logic            o_terminal_ready_out_n_primary,
  output logic            o_terminal_ready_out_n_secondary,
  output logic            o_send_request_out_n_primary,
  output logic            o_send_request_out_n_secondary,
  output logic [7:0]      o_modem_status_reg_primary,
  output logic [7:0]      o_modem_status_reg_secondary,
  output logic            o_modem_irq_primary,
  output logic            o_modem_irq_secondary
);

  umh_state_s state_r;
  umh_state_s state_nxt;

  logic [7:0] modem_control_reg     [2];
  logic [7:0] ier     [2];
  logic       rd      [2];
  logic [3:0] pins_n  [2];

  // Status word from synchronised pins and change flags
  function automatic logic [7:0] status_word(input umh_port_s p);
    logic [7:0] w;
    w = 8'h00;
    w[`UMH_MSR_D_CTS_BIT] = p.flags[0];
    w[`UMH_MSR_D_DSR_BIT] = p.flags[1];
    w[`UMH_MSR_TERI_BIT]  = p.flags[2];
    w[`UMH_MSR_D_DCD_BIT] = p.flags[3];
    w[`UMH_MSR_CTS_BIT]   = ~p.sync2[0]; // see RQ4
    w[`UMH_MSR_DSR_BIT]   = ~p.sync2[1]; // see RQ8
    w[`UMH_MSR_RI_BIT]    = ~p.sync2[2]; // see RQ16
    w[`UMH_MSR_DCD_BIT]   = ~p.sync2[3]; // see RQ11
    return w;
  endfunction

  always_comb
  begin
    modem_control_reg[0]    = i_modem_control_reg_primary;
    modem_control_reg[1]    = i_modem_control_reg_secondary;
    ier[0]    = i_int_enable_primary;
    ier[1]    = i_int_enable_secondary;
    rd[0]     = i_status_read_primary;
    rd[1]     = i_status_read_secondary;
    pins_n[0] = {i_carrier_detect_in_n_primary, i_ring_in_n_primary,
                 i_set_ready_in_n_primary, i_clear_to_send_in_n_primary};
    pins_n[1] = {i_carrier_detect_in_n_secondary, i_ring_in_n_secondary,
                 i_set_ready_in_n_secondary, i_clear_to_send_in_n_secondary};
  end

  // Nothing here touches the transmitter; clear-to-send is status only (see RQ7)
  always_comb
  begin
    logic [3:0] rise;
    logic [3:0] flags;
    logic       loop;
    rise  = 4'h0;
    flags = 4'h0;
    loop  = 1'b0;
    state_nxt = state_r;
    for (int i = 0; i < 2; i++) // see RQ14
    begin
      state_nxt.port[i].sync1 = pins_n[i];
      state_nxt.port[i].sync2 = state_r.port[i].sync1;
      state_nxt.port[i].prev  = state_r.port[i].sync2;
      // Low-to-high on the active-low pin; the edge uses sync2 and prev, not sync1
      rise = state_r.port[i].sync2 & ~state_r.port[i].prev; // see RQ5 RQ9 RQ12 RQ16
      // A rise landing on the read cycle survives the clear
      flags = (rd[i] ? 4'h0 : state_r.port[i].flags) | rise; // see RQ17
      state_nxt.port[i].flags = flags;
      // Interrupt follows held flags, so it stays up until the status read
      state_nxt.port[i].irq = ier[i][`UMH_IER_MODEM_BIT] & (|flags); // see RQ6 RQ10 RQ13 RQ16
      loop = modem_control_reg[i][`UMH_MCR_LOOPBACK_BIT];
      state_nxt.port[i].term_ready_n = ~(modem_control_reg[i][`UMH_MCR_TERM_READY_BIT] & ~loop); // see RQ1 RQ3
      state_nxt.port[i].send_req_n   = ~(modem_control_reg[i][`UMH_MCR_SEND_REQ_BIT] & ~loop); // see RQ15
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        state_r.port[i].sync1        <= `UMH_SYNC_RESET;
        state_r.port[i].sync2        <= `UMH_SYNC_RESET;
        state_r.port[i].prev         <= `UMH_SYNC_RESET;
        state_r.port[i].flags        <= `UMH_FLAG_RESET;
        state_r.port[i].term_ready_n <= `UMH_OUT_RESET_N; // see RQ2
        state_r.port[i].send_req_n   <= `UMH_OUT_RESET_N; // see RQ15
        state_r.port[i].irq          <= 1'b0;
      end
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Status is flop-derived only; inversion of flops keeps outputs glitch-free
  always_comb
  begin
    o_terminal_ready_out_n_primary   = state_r.port[0].term_ready_n;
    o_terminal_ready_out_n_secondary = state_r.port[1].term_ready_n;
    o_send_request_out_n_primary     = state_r.port[0].send_req_n;
    o_send_request_out_n_secondary   = state_r.port[1].send_req_n;
    o_modem_status_reg_primary       = status_word(state_r.port[0]);
    o_modem_status_reg_secondary     = status_word(state_r.port[1]);
    o_modem_irq_primary              = state_r.port[0].irq;
    o_modem_irq_secondary            = state_r.port[1].irq;
  end

endmodule

// [umh_defines.svh]
/*
 * Constants for the dual-port modem handshake block: bit positions in the
 * modem control, modem status and interrupt enable words.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef UMH_DEFINES_SVH
`define UMH_DEFINES_SVH

`define UMH_MCR_TERM_READY_BIT   0
`define UMH_MCR_SEND_REQ_BIT     1
`define UMH_MCR_LOOPBACK_BIT     4
`define UMH_IER_MODEM_BIT        3
`define UMH_MSR_D_CTS_BIT        0
`define UMH_MSR_D_DSR_BIT        1
`define UMH_MSR_TERI_BIT         2
`define UMH_MSR_D_DCD_BIT        3
`define UMH_MSR_CTS_BIT          4
`define UMH_MSR_DSR_BIT          5
`define UMH_MSR_RI_BIT           6
`define UMH_MSR_DCD_BIT          7
`define UMH_OUT_RESET_N          1'h1
`define UMH_SYNC_RESET           4'hf
`define UMH_FLAG_RESET           4'h0

`endif

// [umh_pkg.sv]
/*
 * Types for the dual-port modem handshake block.
 * Assumes umh_defines.svh sits in the include path.
 */
package umh_pkg;

  // One port's handshake state; inputs ordered cts, dsr, ri, dcd
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [3:0] flags;
    logic       term_ready_n;
    logic       send_req_n;
    logic       irq;
  } umh_port_s;

  typedef struct packed {
    umh_port_s [1:0] port;
  } umh_state_s;

endpackage

// [umh_checker_properties.sv]
/* Checker for the primary port of umh_modem_handshake.
   Assumes the bind below attaches it to the design. */
`timescale 1ns/10ps
module umh_checker (
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_modem_control_reg_primary,
  input wire logic [7:0] i_int_enable_primary,
  input wire logic       i_status_read_primary,
  input wire logic       o_terminal_ready_out_n_primary,
  input wire logic       o_send_request_out_n_primary,
  input wire logic [7:0] o_modem_status_reg_primary,
  input wire logic       o_modem_irq_primary
);
  wire [7:0] m = i_modem_control_reg_primary;
  wire [7:0] s = o_modem_status_reg_primary;
  wire       e = i_int_enable_primary[3];
  wire       q = o_modem_irq_primary;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // A flag lands one edge after its current bit drops
  sequence s_cts_off; $fell(s[4]); endsequence
  sequence s_dcd_off; $fell(s[7]); endsequence
  property p_dtr; m[0] && !m[4] |=> !o_terminal_ready_out_n_primary; endproperty
  property p_rts; m[1] && !m[4] |=> !o_send_request_out_n_primary; endproperty
  property p_loop; m[4] |=> o_terminal_ready_out_n_primary && o_send_request_out_n_primary; endproperty
  property p_cts; s_cts_off |=> s[0]; endproperty
  property p_dcd; s_dcd_off |=> s[3]; endproperty
  property p_clr; i_status_read_primary && $stable(s[7:4]) |=> s[3:0] == 4'h0; endproperty
  property p_off; s[3:0] == 4'h0 |-> !q; endproperty
  property p_on; $rose(s[0]) && $stable(e) |-> q == e; endproperty
  a_dtr: assert property (p_dtr) else $error("ready pin high");
  a_rts: assert property (p_rts) else $error("request pin high");
  a_loop: assert property (p_loop) else $error("loopback pins low");
  a_cts: assert property (p_cts) else $error("clear flag missing");
  a_dcd: assert property (p_dcd) else $error("carrier flag missing");
  a_clr: assert property (p_clr) else $error("flags kept");
  a_off: assert property (p_off) else $error("irq without flag");
  a_on: assert property (p_on) else $error("irq wrong");
endmodule
bind umh_modem_handshake umh_checker u_umh_checker (.*);

// [umh_modem_model.sv]
/* Modem model: answers terminal-ready with set-ready and send-request
   with clear-to-send after LAT cycles. Assumes the block clock. */
`timescale 1ns/10ps
module umh_modem_model #(
  parameter int LAT = 1
) (
  input  wire logic i_mclk,
  input  wire logic i_term_n,
  input  wire logic i_req_n,
  output logic      o_clear_n,
  output logic      o_ready_n
);
  logic [7:0] ready_q = 8'hff;
  logic [7:0] clear_q = 8'hff;
  always @(posedge i_mclk)
  begin
    ready_q <= {ready_q[6:0], i_term_n};
    clear_q <= {clear_q[6:0], i_req_n};
  end
  assign o_ready_n = ready_q[LAT-1];
  assign o_clear_n = clear_q[LAT-1];
endmodule

// [umh_modem_handshake_tb.sv]
/* Bench for umh_modem_handshake with a prompt and a slow modem.
   Assumes the model and checker files are compiled first. */
`timescale 1ns/10ps
module umh_modem_handshake_tb;
  logic       clk;
  logic       rst;
  logic [7:0] modem_control_reg [2], ier [2], st [2];
  logic       rd [2], tr [2], rq [2], irq [2], cs [2], sr [2], cd [2], ri [2];
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;
  umh_modem_handshake u_umh_modem_handshake (
    .i_mclk(clk), .i_sys_rst(rst),
    .i_modem_control_reg_primary(modem_control_reg[0]), .i_modem_control_reg_secondary(modem_control_reg[1]),
    .i_int_enable_primary(ier[0]), .i_int_enable_secondary(ier[1]),
    .i_status_read_primary(rd[0]), .i_status_read_secondary(rd[1]),
    .i_clear_to_send_in_n_primary(cs[0]), .i_clear_to_send_in_n_secondary(cs[1]),
    .i_set_ready_in_n_primary(sr[0]), .i_set_ready_in_n_secondary(sr[1]),
    .i_carrier_detect_in_n_primary(cd[0]), .i_carrier_detect_in_n_secondary(cd[1]),
    .i_ring_in_n_primary(ri[0]), .i_ring_in_n_secondary(ri[1]),
    .o_terminal_ready_out_n_primary(tr[0]), .o_terminal_ready_out_n_secondary(tr[1]),
    .o_send_request_out_n_primary(rq[0]), .o_send_request_out_n_secondary(rq[1]),
    .o_modem_status_reg_primary(st[0]), .o_modem_status_reg_secondary(st[1]),
    .o_modem_irq_primary(irq[0]), .o_modem_irq_secondary(irq[1]));
  for (genvar p = 0; p < 2; p++)
  begin : g_modem
    umh_modem_model #(.LAT(1 + 4 * p)) u_modem (.i_mclk(clk), .i_term_n(tr[p]), .i_req_n(rq[p]),
      .o_clear_n(cs[p]), .o_ready_n(sr[p]));
  end
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] pins(int p);
    return {5'h0, tr[p], rq[p], irq[p]};
  endfunction
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd_status(int p);
    rd[p] = 1'h1;
    wt(1);
    rd[p] = 1'h0;
    wt(1);
  endtask
  // Active-going pins set no flag, so the status holds only current bits
  task automatic t_ctl(int p);
    ier[p] = 8'h08;
    modem_control_reg[p] = 8'h03;
    wt(12);
    chk(pins(p), 8'h00);
    chk(st[p], 8'h30);
    chk(st[1-p], 8'h00);
  endtask
  task automatic t_loop(int p);
    modem_control_reg[p] = 8'h13;
    wt(12);
    chk(pins(p), 8'h07);
    chk(st[p], 8'h03);
    rd_status(p);
    chk(st[p], 8'h00);
    chk(pins(p), 8'h06);
  endtask
  task automatic t_car(int p);
    ier[p] = 8'h00;
    cd[p] = 1'h0;
    wt(6);
    chk(st[p], 8'h80);
    cd[p] = 1'h1;
    ri[p] = 1'h0;
    wt(6);
    chk(st[p], 8'h48);
    chk(pins(p), 8'h06);
    ier[p] = 8'h08;
    wt(2);
    chk(pins(p), 8'h07);
    ri[p] = 1'h1;
    wt(6);
    chk(st[p], 8'h0c);
    rd_status(p);
    chk(st[p], 8'h00);
  endtask
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    rst = 1'h1;
    modem_control_reg = '{default: 8'h00};
    ier = '{default: 8'h00};
    rd = '{default: 1'h0};
    cd = '{default: 1'h1};
    ri = '{default: 1'h1};
    wt(8);
    rst = 1'h0;
    wt(2);
    chk(pins(0), 8'h06);
    chk(pins(1), 8'h06);
    for (int p = 0; p < 2; p++)
    begin
      t_ctl(p);
      t_loop(p);
      t_car(p);
    end
    complete_run();
  end
endmodule
